// [hdl/ufir_pkg.sv]
// Shared constants, types and state enumerations for the serial port data and interrupt block.
package ufir_pkg;

	// Register offsets on the three-bit host address.
	localparam logic [2:0] OFF_DATA = 3'h0;
	localparam logic [2:0] OFF_IER  = 3'h1;
	localparam logic [2:0] OFF_FIFO = 3'h2;

	// Interrupt enable field positions.
	localparam int IER_RDA  = 0;
	localparam int IER_THRE = 1;
	localparam int IER_LS   = 2;
	localparam int IER_MS   = 3;

	// FIFO control field positions.
	localparam int FCR_EN       = 0;
	localparam int FCR_RX_FLUSH = 1;
	localparam int FCR_TX_FLUSH = 2;
	localparam int FCR_TRIG_LO  = 6;
	localparam int FCR_TRIG_HI  = 7;

	// Identification codes on bits 3:0.
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LS   = 4'h6;
	localparam logic [3:0] ID_RDA  = 4'h4;
	localparam logic [3:0] ID_TMO  = 4'hc;
	localparam logic [3:0] ID_THRE = 4'h2;
	localparam logic [3:0] ID_MS   = 4'h0;

	// Receive trigger levels in bytes.
	localparam logic [4:0] TRIG_0 = 5'h01;
	localparam logic [4:0] TRIG_1 = 5'h04;
	localparam logic [4:0] TRIG_2 = 5'h08;
	localparam logic [4:0] TRIG_3 = 5'h0e;

	// Reset values.
	localparam logic [3:0] IER_RESET  = 4'h0;
	localparam logic [1:0] TRIG_RESET = 2'h0;

	// Geometry and timing in ticks of the 16x baud strobe.
	localparam int DATA_W        = 8;
	localparam int FIFO_DEPTH    = 16;
	localparam int FIFO_AW       = 4;
	localparam int OVERSAMPLE    = 16;
	localparam int BITS_PER_CHAR = 10;
	localparam int TIMEOUT_CHARS = 4;
	localparam logic [3:0] MID_TICK  = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hf;
	localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_CHARS * BITS_PER_CHAR * OVERSAMPLE);

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ufir_host_req_s;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufir_rx_e;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufir_tx_e;

endpackage

// [hdl/ufir_fifo.sv]
// Byte FIFO with flush and a one-entry mode for non-FIFO operation.
`timescale 1ns/1ps
module ufir_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             one_deep,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [AW:0]           count
);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      count_q;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	// In non-FIFO mode only one entry is usable, which gives the plain holding register.
	assign in_ready  = one_deep ? (count_q == '0) : (count_q != DEPTH_C);
	assign out_valid = count_q != '0;
	assign out_data  = mem[rptr_q];
	assign count     = count_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else if (flush) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else begin
			wptr_q  <= wptr_q + AW'(push);
			rptr_q  <= rptr_q + AW'(pop);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (push && !flush) begin
			mem[wptr_q] <= in_data;
		end
	end
endmodule

// [hdl/ufir_uart.sv]
// Serial port data path, FIFO control and prioritised interrupt identification.
`timescale 1ns/1ps
// What this block does
// - Receive bits LSB first in hidden shifter, then move byte to holding register.
// - Load transmit shifter from holding only after previous byte fully sent, LSB first.
// - Enable bit 0 allows received-data and, in FIFO mode, timeout interrupts.
// - Enable bit 1 allows the transmitter-holding-empty interrupt.
// - Enable bit 2 allows the receiver line status interrupt.
// - Enable bit 3 allows modem status interrupt; enable bits 7:4 read zero.
// - All enables clear: no interrupt, identification reports none.
// - FIFO control bit 0 enables both FIFOs; clearing it disables and flushes them.
// - FIFO control bit 1 flushes receive FIFO, not the shifter; self-clearing.
// - FIFO control bit 2 flushes transmit FIFO, not the shifter; self-clearing.
// - FIFO control bit 3 does nothing; bits 4 and 5 reserved.
// - FIFO control bits 7:6 select receive trigger of 1, 4, 8 or 14 bytes.
// - Priority: line status, received data or timeout, transmit empty, modem status.
// - Identification value held steady while the host is reading it.
// - Identification bit 0 is zero when an enabled interrupt is pending.
// - Identification codes: 0001, 0110, 0100, 1100, 0010, 0000.
// - Identification bit 3 zero outside FIFO mode; set with bit 2 on timeout.
// - Identification bits 7:6 are one when FIFOs enabled; bits 5:4 zero.
// - Timeout after four idle character times with data waiting; receive read clears.
// - Received-data interrupt clears on read or level below trigger.
// - Transmit-empty interrupt clears on identification read reporting it, or holding write.
// - Divisor latch select high moves offsets 0 and 1 to the divisor.
// - Interrupt output driven only while the output gate bit is one.
module ufir_uart (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire ufir_pkg::ufir_host_req_s host_req,
	output logic [7:0]                   rdata,
	input  wire logic                    divisor_latch_select,
	input  wire logic                    irq_output_gate,
	input  wire logic                    line_status_event,
	input  wire logic                    modem_status_event,
	input  wire logic                    baud16_tick,
	input  wire logic                    rxd,
	output logic                         txd,
	output logic                         irq,
	output logic                         rx_overrun
);
	function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
		case (sel)
			2'h0:    trig_bytes = ufir_pkg::TRIG_0;
			2'h1:    trig_bytes = ufir_pkg::TRIG_1;
			2'h2:    trig_bytes = ufir_pkg::TRIG_2;
			default: trig_bytes = ufir_pkg::TRIG_3;
		endcase
	endfunction

	// Host access: a request acts once, on the first cycle that its strobe is high.
	logic       rd_prev_q;
	logic       wr_prev_q;
	logic [7:0] rdata_q;
	logic [3:0] ier_q;
	logic       fifo_en_q;
	logic [1:0] trig_q;
	logic [3:0] id_frozen_q;
	logic       thre_q;
	logic       tx_empty_prev_q;
	logic       ier_thre_prev_q;
	logic       irq_q;
	logic       overrun_q;
	logic [9:0] to_cnt_q;

	wire rd_start = host_req.rd & ~rd_prev_q;
	wire wr_start = host_req.wr & ~wr_prev_q;
	wire sel_data = (host_req.addr == ufir_pkg::OFF_DATA) & ~divisor_latch_select;
	wire sel_ier  = (host_req.addr == ufir_pkg::OFF_IER) & ~divisor_latch_select;
	wire sel_fifo = host_req.addr == ufir_pkg::OFF_FIFO;

	wire thr_wr  = wr_start & sel_data;
	wire ier_wr  = wr_start & sel_ier;
	wire fcr_wr  = wr_start & sel_fifo;
	wire rbr_rd  = rd_start & sel_data;
	wire iir_rd  = rd_start & sel_fifo;

	wire en_change = fcr_wr & (host_req.wdata[ufir_pkg::FCR_EN] != fifo_en_q);
	// other bits honoured only with bit 0 set
	wire fcr_prog  = fcr_wr & host_req.wdata[ufir_pkg::FCR_EN];
	// receive flush is a pulse, so it clears itself
	wire rx_flush  = en_change | (fcr_prog & host_req.wdata[ufir_pkg::FCR_RX_FLUSH]);
	// transmit flush is a pulse, so it clears itself
	wire tx_flush  = en_change | (fcr_prog & host_req.wdata[ufir_pkg::FCR_TX_FLUSH]);

	// Receive path.
	ufir_pkg::ufir_rx_e rx_state_q;
	logic [3:0]         rx_tick_q;
	logic [2:0]         rx_bit_q;
	logic [7:0]         rx_shift_q;
	logic               rx_push;
	logic               rx_ready;
	logic               rx_valid;
	logic [7:0]         rx_data;
	logic [4:0]         rx_count;

	wire rx_pop = rbr_rd & rx_valid;

	ufir_fifo #(
		.WIDTH(ufir_pkg::DATA_W),
		.DEPTH(ufir_pkg::FIFO_DEPTH),
		.AW   (ufir_pkg::FIFO_AW)
	) u_rx_fifo (
		.clk      (clk),
		.rst      (rst),
		.flush    (rx_flush),
		.one_deep (~fifo_en_q),
		.in_valid (rx_push),
		.in_ready (rx_ready),
		.in_data  (rx_shift_q),
		.out_valid(rx_valid),
		.out_ready(rbr_rd),
		.out_data (rx_data),
		.count    (rx_count)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_state_q <= ufir_pkg::RX_IDLE;
			rx_tick_q  <= '0;
			rx_bit_q   <= '0;
			rx_shift_q <= '0;
			rx_push    <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			if (baud16_tick) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				case (rx_state_q)
					ufir_pkg::RX_IDLE: begin
						rx_tick_q <= '0;
						if (!rxd) begin
							rx_state_q <= ufir_pkg::RX_START;
						end
					end
					ufir_pkg::RX_START: begin
						// Recentre on mid-bit so data samples fall in the middle of each bit.
						if (rx_tick_q == ufir_pkg::MID_TICK) begin
							rx_tick_q  <= '0;
							rx_bit_q   <= '0;
							rx_state_q <= rxd ? ufir_pkg::RX_IDLE : ufir_pkg::RX_DATA;
						end
					end
					ufir_pkg::RX_DATA: begin
						if (rx_tick_q == ufir_pkg::LAST_TICK) begin
							rx_shift_q <= {rxd, rx_shift_q[7:1]};
							rx_bit_q   <= rx_bit_q + 3'h1;
							if (rx_bit_q == 3'h7) begin
								rx_state_q <= ufir_pkg::RX_STOP;
							end
						end
					end
					ufir_pkg::RX_STOP: begin
						if (rx_tick_q == ufir_pkg::LAST_TICK) begin
							rx_push    <= 1'b1;
							rx_state_q <= ufir_pkg::RX_IDLE;
						end
					end
					default: rx_state_q <= ufir_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// Transmit path.
	ufir_pkg::ufir_tx_e tx_state_q;
	logic [3:0]         tx_tick_q;
	logic [2:0]         tx_bit_q;
	logic [7:0]         tx_shift_q;
	logic               txd_q;
	logic               tx_ready;
	logic               tx_valid;
	logic [7:0]         tx_data;
	logic [4:0]         tx_count;

	// shifter takes a byte only when idle
	wire tx_load = (tx_state_q == ufir_pkg::TX_IDLE) & tx_valid;

	ufir_fifo #(
		.WIDTH(ufir_pkg::DATA_W),
		.DEPTH(ufir_pkg::FIFO_DEPTH),
		.AW   (ufir_pkg::FIFO_AW)
	) u_tx_fifo (
		.clk      (clk),
		.rst      (rst),
		.flush    (tx_flush),
		.one_deep (~fifo_en_q),
		.in_valid (thr_wr),
		.in_ready (tx_ready),
		.in_data  (host_req.wdata),
		.out_valid(tx_valid),
		.out_ready(tx_load),
		.out_data (tx_data),
		.count    (tx_count)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_state_q <= ufir_pkg::TX_IDLE;
			tx_tick_q  <= '0;
			tx_bit_q   <= '0;
			tx_shift_q <= '0;
		end else if (tx_load) begin
			tx_shift_q <= tx_data;
			tx_tick_q  <= '0;
			tx_bit_q   <= '0;
			tx_state_q <= ufir_pkg::TX_START;
		end else if (baud16_tick) begin
			tx_tick_q <= tx_tick_q + 4'h1;
			if (tx_tick_q == ufir_pkg::LAST_TICK) begin
				case (tx_state_q)
					ufir_pkg::TX_START: tx_state_q <= ufir_pkg::TX_DATA;
					ufir_pkg::TX_DATA: begin
						tx_shift_q <= {1'b0, tx_shift_q[7:1]};
						tx_bit_q   <= tx_bit_q + 3'h1;
						if (tx_bit_q == 3'h7) begin
							tx_state_q <= ufir_pkg::TX_STOP;
						end
					end
					ufir_pkg::TX_STOP: tx_state_q <= ufir_pkg::TX_IDLE;
					default:           tx_state_q <= ufir_pkg::TX_IDLE;
				endcase
			end
		end
	end

	wire txd_d = (tx_state_q == ufir_pkg::TX_START) ? 1'b0 :
	             (tx_state_q == ufir_pkg::TX_DATA) ? tx_shift_q[0] : 1'b1;

	// Character timeout counter, counted in 16x ticks.
	// restarts on any push or pop
	wire to_restart = rx_push | rx_pop | ~rx_valid | ~fifo_en_q | rx_flush;
	wire to_hit     = to_cnt_q == ufir_pkg::TIMEOUT_TICKS;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			to_cnt_q <= '0;
		end else if (to_restart) begin
			to_cnt_q <= '0;
		end else if (baud16_tick && !to_hit) begin
			to_cnt_q <= to_cnt_q + 10'h001;
		end
	end

	// Interrupt sources after enabling.
	wire [4:0] trig_lvl = fifo_en_q ? trig_bytes(trig_q) : 5'h01;
	wire src_ls   = ier_q[ufir_pkg::IER_LS] & line_status_event;
	// received data as a level against the trigger
	wire src_rda  = ier_q[ufir_pkg::IER_RDA] & (rx_count >= trig_lvl);
	wire src_tmo  = ier_q[ufir_pkg::IER_RDA] & fifo_en_q & to_hit;
	// transmit empty source
	// The flag alone could report a holding register that a write has just refilled.
	wire tx_empty = tx_count == '0;
	wire src_thre = ier_q[ufir_pkg::IER_THRE] & thre_q & tx_empty;
	wire src_ms   = ier_q[ufir_pkg::IER_MS] & modem_status_event;

	wire [3:0] id_live = src_ls   ? ufir_pkg::ID_LS   :
	                     src_rda  ? ufir_pkg::ID_RDA  :
	                     src_tmo  ? ufir_pkg::ID_TMO  :
	                     src_thre ? ufir_pkg::ID_THRE :
	                     src_ms   ? ufir_pkg::ID_MS   : ufir_pkg::ID_NONE;

	// hold the code through the read
	wire       iir_busy  = host_req.rd & rd_prev_q & sel_fifo;
	wire [3:0] id_shown  = iir_busy ? id_frozen_q : id_live;
	// pending when bit 0 is low
	wire       any_pend  = ~id_live[0];

	// cleared by a holding write or by reading it as the reported source
	wire thre_clr  = thr_wr | (iir_rd & (id_live == ufir_pkg::ID_THRE));
	wire thre_set  = (tx_empty & ~tx_empty_prev_q) |
	                 (tx_empty & ier_q[ufir_pkg::IER_THRE] & ~ier_thre_prev_q);
	// A new empty event in the same cycle as a clear is kept.
	wire thre_d    = thre_set | (thre_q & ~thre_clr);

	// FIFO flags on bits 7:6, bits 5:4 zero
	wire [7:0] iir_val = {fifo_en_q, fifo_en_q, 2'b00, id_shown};
	wire [7:0] ier_val = {4'h0, ier_q};
	// Offsets 0 and 1 under divisor select belong to the divisor and read zero here.
	wire [7:0] rd_mux  = sel_data ? (rx_valid ? rx_data : 8'h00) :
	                     sel_ier  ? ier_val :
	                     sel_fifo ? iir_val : 8'h00;

	// Host strobe edges and read data.
	// Read data is captured once at read start, so a held strobe cannot pop twice.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
			rdata_q   <= 8'h00;
		end else begin
			rd_prev_q <= host_req.rd;
			wr_prev_q <= host_req.wr;
			if (rd_start) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Interrupt enable and FIFO control.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ier_q     <= ufir_pkg::IER_RESET;
			fifo_en_q <= 1'b0;
			trig_q    <= ufir_pkg::TRIG_RESET;
		end else begin
			if (ier_wr) begin
				ier_q <= host_req.wdata[3:0];
			end
			if (fcr_wr) begin
				fifo_en_q <= host_req.wdata[ufir_pkg::FCR_EN];
			end
			// only trigger bits stored; bits 5:3 have no effect
			if (fcr_prog) begin
				trig_q <= host_req.wdata[ufir_pkg::FCR_TRIG_HI:ufir_pkg::FCR_TRIG_LO];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			id_frozen_q <= ufir_pkg::ID_NONE;
		end else if (iir_rd) begin
			id_frozen_q <= id_live;
		end
	end

	// Transmit-empty flag and its edge detectors.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			thre_q          <= 1'b0;
			tx_empty_prev_q <= 1'b1;
			ier_thre_prev_q <= 1'b0;
		end else begin
			thre_q          <= thre_d;
			tx_empty_prev_q <= tx_empty;
			ier_thre_prev_q <= ier_q[ufir_pkg::IER_THRE];
		end
	end

	// Registered pin outputs.
	// The overrun pulse marks a byte dropped because the receive side was full.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q     <= 1'b0;
			overrun_q <= 1'b0;
			txd_q     <= 1'b1;
		end else begin
			txd_q     <= txd_d;
			overrun_q <= rx_push & ~rx_ready;
			irq_q     <= any_pend & irq_output_gate;
		end
	end

	assign rdata      = rdata_q;
	assign txd        = txd_q;
	assign irq        = irq_q;
	assign rx_overrun = overrun_q;
endmodule

// [test/ufir_uart_checker.sv]
// Port-level assertions for the serial port data and interrupt block.
`timescale 1ns/1ps
module ufir_uart_checker (
	input wire logic                     clk,
	input wire logic                     rst,
	input wire ufir_pkg::ufir_host_req_s host_req,
	input wire logic [7:0]               rdata,
	input wire logic                     divisor_latch_select,
	input wire logic                     irq_output_gate,
	input wire logic                     baud16_tick,
	input wire logic                     txd,
	input wire logic                     irq,
	input wire logic                     rx_overrun
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic       rd_q;
	logic [7:0] low_q;
	wire        rs     = host_req.rd && !rd_q;
	wire        iir_rd = rs && host_req.addr == 3'h2;
	// Ticks spent low on txd; a frame holds at most nine low bits in a row.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q  <= 1'b0;
			low_q <= 8'h00;
		end else begin
			rd_q  <= host_req.rd;
			low_q <= txd ? 8'h00 : low_q + 8'(baud16_tick);
		end
	end
	AST_IRQ_GATED: assert property (!irq_output_gate |=> !irq)
		else $error("irq raised while output gate low");
	AST_IER_HIGH_ZERO: assert property (rs && host_req.addr == 3'h1 |=> rdata[7:4] == 4'h0)
		else $error("enable read upper nibble not zero");
	AST_IIR_MID_ZERO: assert property (iir_rd |=> rdata[5:4] == 2'h0)
		else $error("identification bits 5:4 not zero");
	AST_IIR_CODE: assert property (iir_rd |=> rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
		else $error("identification code not legal");
	AST_TMO_FIFO: assert property (iir_rd |=> !rdata[3] || rdata[7:6] == 2'h3)
		else $error("timeout code outside FIFO mode");
	AST_IIR_IRQ: assert property (iir_rd && irq_output_gate |=> irq == !rdata[0])
		else $error("pending bit disagrees with irq");
	AST_RDATA_HOLD: assert property (!rs |-> ##1 $stable(rdata))
		else $error("read data changed without a read");
	AST_DIV_READ: assert property (rs && divisor_latch_select && host_req.addr < 3'h2
		|=> rdata == 8'h00)
		else $error("divisor select read not zero");
	AST_TX_BIT: assert property ($rose(txd) |-> low_q >= 8'h10 && low_q <= 8'h90)
		else $error("txd low time not whole bits");
	AST_OVR_PULSE: assert property (rx_overrun |=> !rx_overrun)
		else $error("overrun pulse longer than one cycle");
	COV_TMO: cover property (iir_rd ##1 rdata[3:0] == 4'hc);
	COV_OVR: cover property (rx_overrun);
	COV_IRQ: cover property ($rose(irq));
endmodule
bind ufir_uart ufir_uart_checker chk (.clk(clk), .rst(rst), .host_req(host_req), .rdata(rdata),
	.divisor_latch_select(divisor_latch_select), .irq_output_gate(irq_output_gate),
	.baud16_tick(baud16_tick), .txd(txd), .irq(irq), .rx_overrun(rx_overrun));

// [test/ufir_term.sv]
// Remote terminal model: sends characters on rxd and collects characters from txd.
`timescale 1ns/1ps
module ufir_term (
	input  wire logic clk,
	input  wire logic baud16_tick,
	input  wire logic txd,
	output logic      rxd
);
	logic [7:0] got_q[$];
	initial rxd = 1'b1;
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			while (!baud16_tick) @(posedge clk);
		end
	endtask
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			ticks(16);
		end
	endtask
	initial forever begin
		logic [7:0] b;
		@(negedge txd);
		ticks(8);
		for (int i = 0; i < 8; i++) begin
			ticks(16);
			b[i] = txd;
		end
		got_q.push_back(b);
	end
endmodule

// [test/ufir_uart_test.sv]
// Self-checking bench for the serial port data and interrupt block.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got=%h exp=%h", $time, (a), (e)); end end
module ufir_uart_test;
	logic                     clk;
	logic                     rst;
	ufir_pkg::ufir_host_req_s host_req;
	logic [7:0]               rdata;
	logic                     divisor_latch_select;
	logic                     irq_output_gate;
	logic                     line_status_event;
	logic                     modem_status_event;
	logic                     baud16_tick;
	logic                     rxd;
	logic                     txd;
	logic                     irq;
	logic                     rx_overrun;
	logic                     ovr_seen;
	int                       error_cnt;
	int                       check_count;
	int                       cyc;
	int                       lvl[4] = '{1, 4, 8, 14};
	ufir_uart dut (.clk, .rst, .host_req, .rdata, .divisor_latch_select, .irq_output_gate,
		.line_status_event, .modem_status_event, .baud16_tick, .rxd, .txd, .irq, .rx_overrun);
	ufir_term term (.clk, .baud16_tick, .txd, .rxd);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The run needs about 7200 cycles; the ceiling leaves ample margin.
	always @(posedge clk) begin
		cyc++;
		if (rx_overrun === 1'b1) ovr_seen = 1'b1;
		if (cyc == 30000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Strobe high for one cycle, then low for one, so each access is taken once.
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		host_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		host_req.wr = 1'b0;
		host_req.rd = 1'b0;
		@(negedge clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		`CHK(rdata, e)
	endtask
	task automatic rx(input logic [7:0] b);
		term.send(b);
		repeat (3) @(negedge clk);
	endtask
	initial begin
		host_req = '0;
		rst = 1'b1;
		divisor_latch_select = 1'b0;
		irq_output_gate = 1'b1;
		line_status_event = 1'b0;
		modem_status_event = 1'b0;
		baud16_tick = 1'b1;
		ovr_seen = 1'b0;
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		rd(3'h1, 8'h00);
		rd(3'h2, 8'h01);
		wr(3'h1, 8'hff);
		rd(3'h1, 8'h0f);
		rd(3'h2, 8'h02);
		rd(3'h2, 8'h01);
		modem_status_event = 1'b1;
		rd(3'h2, 8'h00);
		line_status_event = 1'b1;
		rd(3'h2, 8'h06);
		`CHK(irq, 1'b1)
		irq_output_gate = 1'b0;
		@(negedge clk);
		`CHK(irq, 1'b0)
		irq_output_gate = 1'b1;
		wr(3'h1, 8'h00);
		rd(3'h2, 8'h01);
		`CHK(irq, 1'b0)
		line_status_event = 1'b0;
		modem_status_event = 1'b0;
		divisor_latch_select = 1'b1;
		wr(3'h1, 8'h05);
		rd(3'h1, 8'h00);
		divisor_latch_select = 1'b0;
		rd(3'h1, 8'h00);
		wr(3'h1, 8'h03);
		rd(3'h2, 8'h02);
		wr(3'h0, 8'h11);
		wr(3'h0, 8'h22);
		rd(3'h2, 8'h01);
		repeat (400) @(negedge clk);
		`CHK(term.got_q.size(), 2)
		`CHK(term.got_q[0], 8'h11)
		`CHK(term.got_q[1], 8'h22)
		rd(3'h2, 8'h02);
		rx(8'h3c);
		rd(3'h2, 8'h04);
		rd(3'h0, 8'h3c);
		rd(3'h2, 8'h01);
		term.send(8'h5a);
		rx(8'h96);
		`CHK(ovr_seen, 1'b1)
		rd(3'h0, 8'h5a);
		wr(3'h1, 8'h01);
		wr(3'h2, 8'h81);
		rd(3'h2, 8'hc1);
		for (int i = 0; i < 4; i++) rx(8'h40 + 8'(i));
		rd(3'h2, 8'hc1);
		repeat (700) @(negedge clk);
		rd(3'h2, 8'hcc);
		rd(3'h0, 8'h40);
		rd(3'h2, 8'hc1);
		// Leftover bytes make the low triggers fire early unless the flush works.
		for (int t = 0; t < 4; t++) begin
			wr(3'h2, {2'(t), 6'h0b});
			for (int i = 1; i < lvl[t]; i++) rx(8'(i));
			rd(3'h2, 8'hc1);
			rx(8'h77);
			rd(3'h2, 8'hc4);
		end
		wr(3'h2, 8'h00);
		rd(3'h2, 8'h01);
		rd(3'h0, 8'h00);
		wr(3'h2, 8'h01);
		term.got_q.delete();
		wr(3'h0, 8'ha5);
		wr(3'h0, 8'hb6);
		wr(3'h0, 8'hc7);
		wr(3'h2, 8'h05);
		repeat (400) @(negedge clk);
		`CHK(term.got_q.size(), 1)
		`CHK(term.got_q[0], 8'ha5)
		end_sim();
	end
endmodule
